// ---- hdl/sbc_map.svh ----
// Constants for the system bus control ends: timing counts and reset values.
// Assumes a single 125 MHz bus clock shared by both ends.
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_CLK_PERIOD_NS    8
`define SBC_GNT_MIN_CLOCKS   2
`define SBC_GNT_CNT_W        2
`define SBC_BEAT_CNT_W       2
`define SBC_IDLE_STROBE_N    1'b1
`define SBC_BOOT_BIT_RESET   1'b0
`define SBC_ADDR_W           32
`endif

// ---- hdl/sbc_pkg.sv ----
// Types shared by the processor end and the memory/master end of the bus.
// Assumes sbc_map.svh is on the include path.
`include "sbc_map.svh"
package sbc_pkg;
   typedef logic [`SBC_ADDR_W-1:0]    sbc_word_type;
   typedef logic [`SBC_BEAT_CNT_W-1:0] sbc_beats_type;
   typedef enum logic [1:0] {
      SBC_END_OK    = 2'h0,
      SBC_END_ERROR = 2'h1,
      SBC_END_RETRY = 2'h2
   } sbc_end_type;
endpackage

// ---- hdl/sbc_bus_if.sv ----
// Interface joining processor end and memory/external-master end.
// Assumes both ends share clk and rst_n; tri-state resolution is in the testbench.
`timescale 1ns/1ns
interface sbc_bus_if;
   import sbc_pkg::*;
   logic         rd_n;
   logic         wr_n;
   logic         xfer_direction;
   logic         instr_data;
   logic         data_phase_on_n;
   logic         last_n;
   logic         ctl_oe;
   sbc_word_type ad_out;
   logic         ad_oe;
   sbc_word_type ad_in;
   logic         ack_n;
   logic         transfer_fault_n;
   logic         retry_n;
   logic         power_on_init_n;
   logic         reset_n;
   logic         mastership_request_n;
   logic         mastership_released_n_out;
   logic         mastership_released_n_oe;
   logic         mastership_released_n_in;
   logic         boot_cfg_drive;
   logic         boot_cfg_oe;
   modport cpu (
      output rd_n, wr_n, xfer_direction, instr_data, data_phase_on_n, last_n, ctl_oe,
      output ad_out, ad_oe, mastership_released_n_out, mastership_released_n_oe,
      input  ad_in, ack_n, transfer_fault_n, retry_n, power_on_init_n, reset_n,
      input  mastership_request_n, mastership_released_n_in
   );
   modport sys (
      input  rd_n, wr_n, xfer_direction, instr_data, data_phase_on_n, last_n, ctl_oe,
      input  ad_out, ad_oe, mastership_released_n_in,
      output ad_in, ack_n, transfer_fault_n, retry_n, power_on_init_n, reset_n,
      output mastership_request_n, boot_cfg_drive, boot_cfg_oe
   );
endinterface

// ---- hdl/sbc_cpu_end.sv ----
// Processor end of the system bus: strobes, data phase, beat tracking,
// error/retry termination, reset inputs and mastership hand-over.
// Assumes bus pins are synchronous to clk and the far end keeps its rules.
//
// Summary of operation
// - Read or write strobe low whole transaction
// - Direction high on write, low on read
// - Data enable low from data phase to end
// - Read acknowledge means valid data; capture it
// - Write acknowledge means beat taken
// - Final beat output low on last beat
// - Fault input ends cycle as bus error
// - Retry input terminates current cycle
// - Read retry ignored after first beat
// - Write retry honoured on every beat
// - Cold reset input forces full initialization
// - Reset input alone gives warm reset
// - Grant on request, reclaim after negation
// - Grant low at least two clocks
// - Grant rises on internal need or negation
// - Grant pin samples boot bit during cold reset
`timescale 1ns/1ns
`include "sbc_map.svh"
module sbc_cpu_end (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   sbc_bus_if.cpu                     bus,
   input  wire logic                  req_valid,
   input  wire logic                  req_write,
   input  wire logic                  req_instr,
   input  wire sbc_pkg::sbc_beats_type req_beats,
   input  wire sbc_pkg::sbc_word_type  req_addr,
   input  wire sbc_pkg::sbc_word_type  req_wdata,
   output logic                       req_ready,
   output logic                       rdata_valid,
   output sbc_pkg::sbc_word_type      rdata,
   output logic                       done,
   output sbc_pkg::sbc_end_type       done_status,
   output logic                       warm_reset_seen,
   output logic                       boot_config_bit
);
   import sbc_pkg::*;

   typedef enum logic [2:0] {
      SBC_IDLE    = 3'h0,
      SBC_ADDR    = 3'h1,
      SBC_DATA    = 3'h3,
      SBC_GRANTED = 3'h2,
      SBC_RECLAIM = 3'h6
   } sbc_cpu_state_type;

   typedef struct packed {
      sbc_cpu_state_type                  st;
      logic                               write;
      logic                               instr;
      sbc_beats_type                      left;
      logic                               first_taken;
      sbc_word_type                       addr;
      sbc_word_type                       wdata;
      logic [`SBC_GNT_CNT_W-1:0]          gcnt;
      logic                               gnt_n;
      logic                               req_ready;
      logic                               rdata_valid;
      sbc_word_type                       rdata;
      logic                               done;
      sbc_end_type                        status;
      logic                               warm;
      logic                               boot;
   } sbc_cpu_reg_type;

   sbc_cpu_reg_type r_q;
   sbc_cpu_reg_type r_d;
   logic            cold_n;
   logic            in_cycle;

   assign cold_n   = bus.power_on_init_n;
   assign in_cycle = (r_q.st == SBC_ADDR) || (r_q.st == SBC_DATA);

   always_comb begin
      r_d             = r_q;
      r_d.rdata_valid = 1'b0;
      r_d.done        = 1'b0;
      r_d.req_ready   = 1'b0;
      unique case (r_q.st)
         SBC_IDLE: begin
            if (!bus.mastership_request_n) begin
               r_d.st    = SBC_GRANTED;
               r_d.gnt_n = 1'b0;
               r_d.gcnt  = '0;
            end else if (req_valid) begin
               r_d.st          = SBC_ADDR;
               r_d.write       = req_write;
               r_d.instr       = req_instr;
               r_d.left        = req_beats;
               r_d.addr        = req_addr;
               r_d.wdata       = req_wdata;
               r_d.first_taken = 1'b0;
               r_d.req_ready   = 1'b1;
            end
         end
         SBC_ADDR: begin
            r_d.st = SBC_DATA;
         end
         SBC_DATA: begin
            if (!bus.transfer_fault_n) begin
               r_d.st     = SBC_IDLE;
               r_d.done   = 1'b1;
               r_d.status = SBC_END_ERROR;
            end else if (!bus.retry_n && (r_q.write || !r_q.first_taken)) begin
               r_d.st     = SBC_IDLE;
               r_d.done   = 1'b1;
               r_d.status = SBC_END_RETRY;
            end else if (!bus.ack_n) begin
               r_d.first_taken = 1'b1;
               if (!r_q.write) begin
                  r_d.rdata_valid = 1'b1;
                  r_d.rdata       = bus.ad_in;
               end
               if (r_q.left == '0) begin
                  r_d.st     = SBC_IDLE;
                  r_d.done   = 1'b1;
                  r_d.status = SBC_END_OK;
               end else begin
                  r_d.left = r_q.left - 1'b1;
               end
            end
         end
         SBC_GRANTED: begin
            if (r_q.gcnt != `SBC_GNT_CNT_W'(`SBC_GNT_MIN_CLOCKS - 1)) begin
               r_d.gcnt = r_q.gcnt + 1'b1;
            end else if (bus.mastership_request_n || req_valid) begin
               r_d.gnt_n = 1'b1;
               r_d.st    = bus.mastership_request_n ? SBC_IDLE : SBC_RECLAIM;
            end
         end
         SBC_RECLAIM: begin
            if (bus.mastership_request_n) begin
               r_d.st = SBC_IDLE;
            end
         end
         default: begin
            r_d.st = SBC_IDLE;
         end
      endcase
      if (!bus.reset_n && cold_n) begin
         r_d.warm = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q        <= '0;
         r_q.st     <= SBC_IDLE;
         r_q.gnt_n  <= `SBC_IDLE_STROBE_N;
         r_q.status <= SBC_END_OK;
         r_q.boot   <= `SBC_BOOT_BIT_RESET;
      end else if (!cold_n) begin
         r_q        <= '0;
         r_q.st     <= SBC_IDLE;
         r_q.gnt_n  <= `SBC_IDLE_STROBE_N;
         r_q.status <= SBC_END_OK;
         r_q.boot   <= bus.mastership_released_n_in;
      end else if (!bus.reset_n) begin
         r_q.st    <= SBC_IDLE;
         r_q.gnt_n <= `SBC_IDLE_STROBE_N;
         r_q.warm  <= 1'b1;
         r_q.done  <= 1'b0;
         r_q.req_ready   <= 1'b0;
         r_q.rdata_valid <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // Bus pins: strobes, direction, indicator and data phase enable
   always_comb begin
      bus.rd_n            = !(in_cycle && !r_q.write);
      bus.wr_n            = !(in_cycle && r_q.write);
      bus.xfer_direction  = in_cycle && r_q.write;
      bus.instr_data      = in_cycle && r_q.instr;
      bus.data_phase_on_n = !(r_q.st == SBC_DATA);
      bus.last_n          = !(r_q.st == SBC_DATA && r_q.left == '0);
      bus.ctl_oe          = cold_n && (r_q.st != SBC_GRANTED) && (r_q.st != SBC_RECLAIM);
      bus.ad_oe           = (r_q.st == SBC_ADDR) || (r_q.st == SBC_DATA && r_q.write);
      bus.ad_out          = (r_q.st == SBC_ADDR) ? r_q.addr : r_q.wdata;
      bus.mastership_released_n_out = r_q.gnt_n;
      bus.mastership_released_n_oe  = cold_n;
   end

   assign req_ready       = r_q.req_ready;
   assign rdata_valid     = r_q.rdata_valid;
   assign rdata           = r_q.rdata;
   assign done            = r_q.done;
   assign done_status     = r_q.status;
   assign warm_reset_seen = r_q.warm;
   assign boot_config_bit = r_q.boot;
endmodule

// ---- hdl/sbc_sys_end.sv ----
// Memory system and external master end of the system bus.
// Assumes the processor end drives the strobes synchronously to clk.
`timescale 1ns/1ns
`include "sbc_map.svh"
module sbc_sys_end (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   sbc_bus_if.sys                    bus,
   input  wire logic                 cold_req,
   input  wire logic                 warm_req,
   input  wire logic                 boot_bit,
   input  wire logic                 ack_go,
   input  wire logic                 fault_go,
   input  wire logic                 retry_go,
   input  wire sbc_pkg::sbc_word_type read_data,
   input  wire logic                 dma_want,
   output logic                      dma_owns,
   output logic                      wbeat_valid,
   output sbc_pkg::sbc_word_type     wbeat_data
);
   import sbc_pkg::*;

   typedef struct packed {
      logic         cold_n;
      logic         reset_n;
      logic         ack_n;
      logic         fault_n;
      logic         retry_n;
      sbc_word_type rdata;
      logic         breq_n;
      logic         owns;
      logic         wvalid;
      sbc_word_type wdata;
   } sbc_sys_reg_type;

   sbc_sys_reg_type r_q;
   sbc_sys_reg_type r_d;
   logic            in_data;
   logic            beat_now;

   assign in_data  = !bus.data_phase_on_n && bus.ctl_oe;
   assign beat_now = in_data && !r_q.ack_n;

   always_comb begin
      r_d         = r_q;
      r_d.cold_n  = !cold_req;
      r_d.reset_n = !(cold_req || warm_req);
      r_d.ack_n   = !(in_data && ack_go && r_q.ack_n && !beat_now);
      r_d.rdata   = read_data;
      r_d.fault_n = !(in_data && fault_go);
      r_d.retry_n = !(in_data && retry_go);
      r_d.breq_n  = !dma_want;
      r_d.owns    = !bus.mastership_released_n_in && !r_q.breq_n;
      r_d.wvalid  = beat_now && bus.xfer_direction;
      r_d.wdata   = bus.ad_out;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q         <= '0;
         r_q.cold_n  <= 1'b0;
         r_q.reset_n <= 1'b0;
         r_q.ack_n   <= 1'b1;
         r_q.fault_n <= 1'b1;
         r_q.retry_n <= 1'b1;
         r_q.breq_n  <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign bus.power_on_init_n      = r_q.cold_n;
   assign bus.reset_n              = r_q.reset_n;
   assign bus.ack_n                = r_q.ack_n;
   assign bus.ad_in                = r_q.rdata;
   assign bus.transfer_fault_n     = r_q.fault_n;
   assign bus.retry_n              = r_q.retry_n;
   assign bus.mastership_request_n = r_q.breq_n;
   assign bus.boot_cfg_drive       = boot_bit;
   assign bus.boot_cfg_oe          = !r_q.cold_n;
   assign dma_owns                 = r_q.owns;
   assign wbeat_valid              = r_q.wvalid;
   assign wbeat_data               = r_q.wdata;
endmodule

// ---- bench/sbc_bus_assertions.sv ----
// Checker for the bus between the processor end and the system end.
// Assumes it sits beside the interface and shares its clock and reset.
`timescale 1ns/1ns
module sbc_bus_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic xfer_direction,
   input wire logic data_phase_on_n,
   input wire logic last_n,
   input wire logic ctl_oe,
   input wire logic ad_oe,
   input wire logic ack_n,
   input wire logic transfer_fault_n,
   input wire logic retry_n,
   input wire logic power_on_init_n,
   input wire logic mastership_released_n_out,
   input wire logic mastership_released_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_dir_wr; !wr_n |-> xfer_direction; endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("direction low in write");
   property p_dir_rd; !rd_n |-> !xfer_direction; endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("direction high in read");
   property p_strobe; !data_phase_on_n |-> (rd_n != wr_n); endproperty
   a_strobe: assert property (p_strobe) else $error("no single strobe in data");
   property p_den_on; $fell(rd_n) || $fell(wr_n) |=> !data_phase_on_n; endproperty
   a_den_on: assert property (p_den_on) else $error("data phase late");
   property p_den_off; !ack_n && !last_n && !data_phase_on_n |=> data_phase_on_n; endproperty
   a_den_off: assert property (p_den_off) else $error("data phase outlives last ack");
   property p_last; !last_n |-> !data_phase_on_n; endproperty
   a_last: assert property (p_last) else $error("last beat outside data phase");
   property p_fault; !transfer_fault_n && !data_phase_on_n |=> rd_n && wr_n; endproperty
   a_fault: assert property (p_fault) else $error("fault did not end cycle");
   property p_wretry; !retry_n && !wr_n && !data_phase_on_n |=> wr_n; endproperty
   a_wretry: assert property (p_wretry) else $error("write retry ignored");
   property p_gnt; $fell(mastership_released_n_out) |=> !mastership_released_n_out; endproperty
   a_gnt: assert property (p_gnt) else $error("grant shorter than two clocks");
   property p_float;
      !mastership_released_n_out && mastership_released_n_oe |-> !ctl_oe && !ad_oe;
   endproperty
   a_float: assert property (p_float) else $error("bus driven while released");
   property p_boot; !power_on_init_n && !$past(power_on_init_n) |-> !mastership_released_n_oe;
   endproperty
   a_boot: assert property (p_boot) else $error("grant driven in cold reset");
   c_wr: cover property (!wr_n && !ack_n && !last_n);
   c_rd: cover property (!rd_n && !ack_n && !last_n);
   c_gnt: cover property (!mastership_released_n_out && mastership_released_n_oe);
endmodule

// ---- bench/cpu_system_bus_control_bench.sv ----
// Bench joining the processor end and the system end through the bus interface.
// Assumes the grant pin has a pull-up and is resolved here.
`timescale 1ns/1ns
module cpu_system_bus_control_bench;
   import sbc_pkg::*;
   logic clk = 0, rst_n = 0, rv = 0, rw = 0, ri = 0, cold = 0, warm = 0, bootb = 0;
   logic ackg = 1, flt = 0, rty = 0, dma = 0, arm = 0, rdy, rdv, dn, wseen, bootq, own, wbv, idv;
   sbc_beats_type rb = '0;
   sbc_word_type ra = '0, wd = '0, rdat = 32'h5A5A_0001, rdq, wbd, lrd, lwd;
   sbc_end_type st, dst;
   int failures = 0, checked = 0, nr = 0, nw = 0, n;
   sbc_bus_if bus_if ();
   assign bus_if.mastership_released_n_in = bus_if.mastership_released_n_oe ?
      bus_if.mastership_released_n_out : (bus_if.boot_cfg_oe ? bus_if.boot_cfg_drive : 1'b1);
   sbc_cpu_end sbc_cpu_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if), .req_valid(rv),
      .req_write(rw), .req_instr(ri), .req_beats(rb), .req_addr(ra), .req_wdata(wd),
      .req_ready(rdy), .rdata_valid(rdv), .rdata(rdq), .done(dn), .done_status(dst),
      .warm_reset_seen(wseen), .boot_config_bit(bootq));
   sbc_sys_end sbc_sys_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if), .cold_req(cold),
      .warm_req(warm), .boot_bit(bootb), .ack_go(ackg), .fault_go(flt), .retry_go(rty),
      .read_data(rdat), .dma_want(dma), .dma_owns(own), .wbeat_valid(wbv), .wbeat_data(wbd));
   sbc_bus_assertions sbc_bus_assertions_inst (.clk(clk), .rst_n(rst_n), .rd_n(bus_if.rd_n),
      .wr_n(bus_if.wr_n), .xfer_direction(bus_if.xfer_direction),
      .data_phase_on_n(bus_if.data_phase_on_n), .last_n(bus_if.last_n),
      .ctl_oe(bus_if.ctl_oe), .ad_oe(bus_if.ad_oe), .ack_n(bus_if.ack_n),
      .transfer_fault_n(bus_if.transfer_fault_n), .retry_n(bus_if.retry_n),
      .power_on_init_n(bus_if.power_on_init_n),
      .mastership_released_n_out(bus_if.mastership_released_n_out),
      .mastership_released_n_oe(bus_if.mastership_released_n_oe));
   always #4 clk = ~clk;
   // Beat tallies and the late retry that follows the first beat
   always @(posedge clk) begin
      if (rdv === 1'b1) begin
         nr <= nr + 1;
         lrd <= rdq;
      end
      if (wbv === 1'b1) begin
         nw <= nw + 1;
         lwd <= wbd;
      end
      if (!bus_if.rd_n) idv <= bus_if.instr_data;
      if (arm && (rdv === 1'b1 || wbv === 1'b1)) rty <= 1'b1;
   end
   task automatic chk_w(string nm, sbc_word_type e, sbc_word_type g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_b(string nm, logic e, logic g);
      chk_w(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic chk_e(string nm, sbc_end_type e);
      chk_w(nm, {30'h0, e}, {30'h0, st});
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic xfer(logic w, logic i, sbc_beats_type b, sbc_word_type d);
      nr = 0;
      nw = 0;
      @(posedge clk);
      {rv, rw, ri, rb, wd, ra} <= {1'b1, w, i, b, d, d ^ 32'h0000_1000};
      n = 0;
      do begin @(negedge clk); n++; end while (rdy !== 1'b1 && n < 60);
      @(posedge clk) rv <= 1'b0;
      do begin @(negedge clk); n++; end while (dn !== 1'b1 && n < 120);
      chk_b("done", 1'b1, dn);
      st = dst;
      // Let the beat tallies settle and hand back on a rising edge
      repeat (2) @(posedge clk);
   endtask
   task automatic flag(logic e);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (bus_if.mastership_released_n_in !== e && k < 40);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(0, 1, 2'h0, 0);
      chk_e("st", SBC_END_OK);
      chk_b("idv", 1, idv);
      chk_w("rd", rdat, lrd);
      chk_w("nr", 1, nr);
      xfer(1, 0, 2'h3, 32'hC0DE_0004);
      chk_e("st", SBC_END_OK);
      chk_w("nw", 4, nw);
      chk_w("wd", 32'hC0DE_0004, lwd);
      $display("test basic done");
      flt <= 1;
      xfer(0, 0, 2'h1, 0);
      chk_e("st", SBC_END_ERROR);
      chk_w("nr", 0, nr);
      chk_b("idv", 0, idv);
      flt <= 0;
      {ackg, rty} <= 2'b01;
      xfer(0, 0, 2'h0, 0);
      chk_e("st", SBC_END_RETRY);
      {ackg, rty, arm} <= 3'b101;
      xfer(0, 0, 2'h3, 0);
      chk_e("st", SBC_END_OK);
      chk_w("nr", 4, nr);
      rty <= 0;
      xfer(1, 0, 2'h3, 1);
      chk_e("st", SBC_END_RETRY);
      chk_b("nw", 1, (nw > 0) && (nw < 4));
      {rty, arm} <= 2'b00;
      $display("test terminations done");
      dma <= 1;
      flag(0);
      repeat (3) @(negedge clk);
      chk_b("gnt", 0, bus_if.mastership_released_n_in);
      chk_b("own", 1, own);
      chk_b("ctl", 0, bus_if.ctl_oe);
      @(posedge clk);
      dma <= 0;
      flag(1);
      chk_b("gnt", 1, bus_if.mastership_released_n_in);
      @(posedge clk);
      dma <= 1;
      flag(0);
      // Internal need raises the grant; the cycle waits for the request to drop
      fork
         xfer(0, 0, 2'h0, 0);
         begin
            flag(1);
            chk_b("req", 0, bus_if.mastership_request_n);
            chk_b("rd", 1, bus_if.rd_n);
            @(posedge clk);
            dma <= 0;
         end
      join
      chk_e("st", SBC_END_OK);
      chk_w("nr", 1, nr);
      $display("test mastership done");
      chk_b("warm", 0, wseen);
      warm <= 1;
      repeat (4) @(posedge clk);
      warm <= 0;
      repeat (4) @(posedge clk);
      chk_b("warm", 1, wseen);
      {cold, bootb} <= 2'b11;
      repeat (6) @(negedge clk);
      chk_b("boot", 1, bootq);
      chk_b("warm", 0, wseen);
      @(posedge clk);
      cold <= 0;
      repeat (6) @(posedge clk);
      xfer(0, 0, 2'h0, 0);
      chk_e("st", SBC_END_OK);
      chk_w("nr", 1, nr);
      $display("test resets done");
      final_report;
   end
   initial begin
      #40000;
      failures++;
      final_report;
   end
endmodule
